// File: include/cpsb_pkg.sv
/*
  Package for the status word and bank addressing block: field positions,
  reset values, address windows and the carrier structs.
  Assumes a single machine clock and 8-bit data operations.
*/
package cpsb_pkg;

  localparam int          SW_W          = 16;
  localparam int          BANK_HI       = 15;
  localparam int          BANK_LO       = 11;
  localparam int          DWIN_HI       = 10;
  localparam int          DWIN_LO       = 8;
  localparam int          FLAG_HALF     = 7;
  localparam int          FLAG_IEN      = 6;
  localparam int          FLAG_LVL_HI   = 5;
  localparam int          FLAG_LVL_LO   = 4;
  localparam int          FLAG_NEG      = 3;
  localparam int          FLAG_ZERO     = 2;
  localparam int          FLAG_OVF      = 1;
  localparam int          FLAG_CARRY    = 0;
  localparam logic [4:0]  BANK_RST      = 5'h00;
  localparam logic [2:0]  DWIN_RST      = 3'h0;
  localparam logic [7:0]  FLAGS_RST     = 8'h30;
  localparam logic [1:0]  LVL_RST       = 2'h3;
  localparam logic [15:0] MIRROR_ADDR   = 16'h0078;
  localparam logic [7:0]  GREG_PAGE     = 8'h01;
  localparam logic [15:0] GREG_BASE     = 16'h0100;
  localparam logic [15:0] GREG_TOP      = 16'h01FF;
  localparam logic [15:0] DIR_FIXED_TOP = 16'h007F;
  localparam logic [15:0] DIR_WIN_BASE  = 16'h0080;

  // Flag update request from the execution datapath
  typedef struct packed {
    logic       valid;
    logic       is_shift;
    logic       shift_out;
    logic       is_sub;
    logic [7:0] opa;
    logic [7:0] opb;
    logic       cin;
  } cpsb_alu_req_t;

  // Mirror address port access
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } cpsb_mirror_req_t;

endpackage : cpsb_pkg

// File: hw/cpsb_flag_calc.sv
/*
  Flag calculator: derives half carry, negative, zero, overflow and
  carry for an 8-bit add or subtract, or a shift carry-out.
  Assumes operands are stable in the cycle the request is valid.
*/
`timescale 1ns/1ps
module cpsb_flag_calc
  import cpsb_pkg::*;
(
  input  cpsb_pkg::cpsb_alu_req_t req,
  output logic [7:0]               result,
  output logic [4:0]               flags
);
  logic [8:0] full;
  logic [4:0] low;
  logic [7:0] b_eff;

  always_comb begin
    b_eff = req.is_sub ? ~req.opb : req.opb;
    // Subtract as a + ~b + ~borrow keeps one adder
    full  = {1'b0, req.opa} + {1'b0, b_eff}
            + {8'h00, req.is_sub ^ req.cin};
    low   = {1'b0, req.opa[3:0]} + {1'b0, b_eff[3:0]}
            + {4'h0, req.is_sub ^ req.cin};
    result = full[7:0];
    flags[4] = low[4] ^ req.is_sub;
    flags[3] = full[7];
    flags[2] = (full[7:0] == 8'h00);
    flags[1] = (req.opa[7] == b_eff[7]) && (full[7] != req.opa[7]);
    flags[0] = req.is_shift ? req.shift_out : (full[8] ^ req.is_sub);
  end
endmodule : cpsb_flag_calc

// File: hw/cpsb_addr_map.sv
/*
  Address translation: general register and direct operand addresses.
  Assumes the bank and window selectors come from the status word.
*/
`timescale 1ns/1ps
module cpsb_addr_map
  import cpsb_pkg::*;
(
  input  logic [4:0]  bank,
  input  logic [2:0]  dwin,
  input  logic [2:0]  reg_idx,
  input  logic [7:0]  dir_op,
  output logic [15:0] greg_addr,
  output logic [15:0] dir_addr
);
  always_comb begin
    greg_addr = {GREG_PAGE, bank, reg_idx};
    if (dir_op[7] == 1'b0) begin
      dir_addr = {8'h00, dir_op};
    end else begin
      // Window 0 lands on 0x80, each step adds 128 bytes
      dir_addr = DIR_WIN_BASE + {6'h00, dwin, dir_op[6:0]};
    end
  end
endmodule : cpsb_addr_map

// File: hw/cpsb_status_word.sv
/*
  Status word of the CPU core: bank selector, direct window selector and
  condition flags, with address translation and interrupt gating.
  Assumes the decoder presents at most one write source per cycle and
  handles byte ordering of memory cycles through the helper outputs.
*/
`timescale 1ns/1ps
module cpsb_status_word
  import cpsb_pkg::*;
(
  input  logic                        clock,
  input  logic                        reset_n,
  input  logic                        clk_en,
  input  logic                        sw_wr,
  input  logic [15:0]                 sw_wdata,
  input  cpsb_pkg::cpsb_mirror_req_t  mirror,
  input  cpsb_pkg::cpsb_alu_req_t     alu,
  input  logic                        irq_enable_instruction,
  input  logic                        irq_disable_instruction,
  input  logic                        lvl_wr,
  input  logic [1:0]                  lvl_wdata,
  input  logic [2:0]                  reg_idx,
  input  logic [7:0]                  dir_op,
  input  logic                        irq_req,
  input  logic [1:0]                  irq_req_level,
  input  logic [15:0]                 word_in,
  input  logic [7:0]                  byte_hi_in,
  input  logic [7:0]                  byte_lo_in,
  output logic [15:0]                 status_word_ff,
  output logic [7:0]                  mirror_rdata_ff,
  output logic                        mirror_hit_ff,
  output logic [15:0]                 greg_addr_ff,
  output logic [15:0]                 dir_addr_ff,
  output logic [7:0]                  alu_result_ff,
  output logic                        irq_accept_ff,
  output logic [7:0]                  mem_byte_lo_addr_ff,
  output logic [7:0]                  mem_byte_hi_addr_ff,
  output logic [15:0]                 word_joined_ff
);
  import cpsb_pkg::*;

  logic [4:0]  bank_selector_ff;
  logic [2:0]  direct_window_selector_ff;
  logic [7:0]  condition_flags_byte_ff;
  logic [7:0]  calc_result;
  logic [4:0]  calc_flags;
  logic [15:0] nxt_greg_addr;
  logic [15:0] nxt_dir_addr;
  logic        mirror_sel;
  logic [15:0] nxt_status_word;

  cpsb_flag_calc u_flag_calc (
    .req    (alu),
    .result (calc_result),
    .flags  (calc_flags)
  );

  cpsb_addr_map u_addr_map (
    .bank      (bank_selector_ff),
    .dwin      (direct_window_selector_ff),
    .reg_idx   (reg_idx),
    .dir_op    (dir_op),
    .greg_addr (nxt_greg_addr),
    .dir_addr  (nxt_dir_addr)
  );

  assign mirror_sel = (mirror.addr == MIRROR_ADDR);

  // Selectors: whole word write first, mirror write otherwise
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bank_selector_ff          <= BANK_RST;
      direct_window_selector_ff <= DWIN_RST;
    end else if (clk_en) begin
      if (sw_wr) begin
        bank_selector_ff          <= sw_wdata[BANK_HI:BANK_LO];
        direct_window_selector_ff <= sw_wdata[DWIN_HI:DWIN_LO];
      end else if (mirror.wr && mirror_sel) begin
        // Mirror write leaves the level bits alone
        bank_selector_ff          <= mirror.wdata[7:3];
        direct_window_selector_ff <= mirror.wdata[2:0];
      end
    end
  end

  // Flags byte: no mirror path, only word write, datapath events, interrupt enable/disable instructions or level write
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      condition_flags_byte_ff <= FLAGS_RST;
    end else if (clk_en) begin
      if (sw_wr) begin
        condition_flags_byte_ff <= sw_wdata[7:0];
      end else begin
        if (alu.valid) begin
          condition_flags_byte_ff[FLAG_HALF]  <= calc_flags[4];
          condition_flags_byte_ff[FLAG_NEG]   <= calc_flags[3];
          condition_flags_byte_ff[FLAG_ZERO]  <= calc_flags[2];
          condition_flags_byte_ff[FLAG_OVF]   <= calc_flags[1];
          condition_flags_byte_ff[FLAG_CARRY] <= calc_flags[0];
        end
        // Set wins if both instructions are somehow decoded together
        if (irq_enable_instruction) begin
          condition_flags_byte_ff[FLAG_IEN] <= 1'b1;
        end else if (irq_disable_instruction) begin
          condition_flags_byte_ff[FLAG_IEN] <= 1'b0;
        end
        if (lvl_wr) begin
          condition_flags_byte_ff[FLAG_LVL_HI:FLAG_LVL_LO] <= lvl_wdata;
        end
      end
    end
  end

  always_comb begin
    nxt_status_word = {bank_selector_ff, direct_window_selector_ff,
                       condition_flags_byte_ff};
  end

  // Registered views of the word and the mirror
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      status_word_ff  <= {BANK_RST, DWIN_RST, FLAGS_RST};
      mirror_rdata_ff <= 8'h00;
      mirror_hit_ff   <= 1'b0;
    end else if (clk_en) begin
      status_word_ff  <= nxt_status_word;
      mirror_rdata_ff <= {bank_selector_ff,
                          direct_window_selector_ff};
      mirror_hit_ff   <= mirror_sel;
    end
  end

  // Translated addresses, one cycle after selector and operand
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      greg_addr_ff <= GREG_BASE;
      dir_addr_ff  <= 16'h0000;
    end else if (clk_en) begin
      greg_addr_ff <= nxt_greg_addr;
      dir_addr_ff  <= nxt_dir_addr;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      alu_result_ff <= 8'h00;
    end else if (clk_en && alu.valid) begin
      alu_result_ff <= calc_result;
    end
  end

  // Strict less-than: level 0 in the word blocks every request
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      irq_accept_ff <= 1'b0;
    end else if (clk_en) begin
      irq_accept_ff <= irq_req && condition_flags_byte_ff[FLAG_IEN]
        && (irq_req_level <
            condition_flags_byte_ff[FLAG_LVL_HI:FLAG_LVL_LO]);
    end
  end

  // Big-endian: high byte goes to the lower address
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      mem_byte_lo_addr_ff <= 8'h00;
      mem_byte_hi_addr_ff <= 8'h00;
      word_joined_ff      <= 16'h0000;
    end else if (clk_en) begin
      mem_byte_lo_addr_ff <= word_in[15:8];
      mem_byte_hi_addr_ff <= word_in[7:0];
      word_joined_ff      <= {byte_hi_in, byte_lo_in};
    end
  end

endmodule : cpsb_status_word

// File: sim/cpsb_sva.sv
/* Assertions on the ports of the status word block.
   Bound to cpsb_status_word; single clock, reset low. */
`timescale 1ns/1ps
module cpsb_sva
  import cpsb_pkg::*;
(
  input logic        clock,
  input logic        reset_n,
  input logic        clk_en,
  input logic        sw_wr,
  input logic [15:0] sw_wdata,
  input cpsb_pkg::cpsb_mirror_req_t mirror,
  input cpsb_pkg::cpsb_alu_req_t    alu,
  input logic        irq_enable_instruction,
  input logic        irq_disable_instruction,
  input logic        lvl_wr,
  input logic [2:0]  reg_idx,
  input logic [7:0]  dir_op,
  input logic        irq_req,
  input logic [1:0]  irq_req_level,
  input logic [15:0] status_word_ff,
  input logic [15:0] greg_addr_ff,
  input logic [15:0] dir_addr_ff,
  input logic [7:0]  alu_result_ff,
  input logic        irq_accept_ff
);
  logic wrote_ff;
  // Copy lags live state by one edge after any write
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      wrote_ff <= 1'b0;
    end else begin
      wrote_ff <= sw_wr | mirror.wr | lvl_wr | irq_enable_instruction
                  | irq_disable_instruction;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  reset_val_a: assert property (
    $rose(reset_n) |-> status_word_ff == 16'h0030)
    else $error("status word not at reset value");
  greg_map_a: assert property (clk_en && !wrote_ff |=> greg_addr_ff ==
    {GREG_PAGE, $past(status_word_ff[15:11]), $past(reg_idx)})
    else $error("register address wrong");
  dir_low_a: assert property (
    clk_en && !dir_op[7] |=> dir_addr_ff == {8'h00, $past(dir_op)})
    else $error("low direct operand moved");
  dir_win_a: assert property (clk_en && dir_op[7] && !wrote_ff |=>
    dir_addr_ff == DIR_WIN_BASE + {6'h00, $past(status_word_ff[10:8]),
    $past(dir_op[6:0])}) else $error("direct window address wrong");
  sw_write_a: assert property (
    clk_en && sw_wr ##1 clk_en |=> status_word_ff == $past(sw_wdata, 2))
    else $error("word write lost");
  mirror_wr_a: assert property (clk_en && !sw_wr && mirror.wr &&
    mirror.addr == MIRROR_ADDR ##1 clk_en |=>
    status_word_ff[15:8] == $past(mirror.wdata, 2))
    else $error("mirror write lost");
  flag_nz_a: assert property (clk_en && alu.valid && !sw_wr ##1
    clk_en && !alu.valid |=> status_word_ff[3:2] ==
    {alu_result_ff[7], alu_result_ff == 8'h00}) else $error("N or Z wrong");
  irq_gate_a: assert property (clk_en && !wrote_ff |=> irq_accept_ff ==
    ($past(irq_req) && $past(status_word_ff[6]) &&
    $past(irq_req_level) < $past(status_word_ff[5:4])))
    else $error("interrupt gate wrong");
  cover property (clk_en && sw_wr);
  cover property (irq_accept_ff);
  cover property (alu.valid && alu.is_shift);
endmodule : cpsb_sva
bind cpsb_status_word cpsb_sva u_sva (.*);

// File: sim/cpsb_cpu_model.sv
/* Behavioural decoder side: issues flag updates and mirror writes.
   Assumes op is held one cycle per request by the bench. */
`timescale 1ns/1ps
module cpsb_cpu_model
  import cpsb_pkg::*;
(
  input  logic                       clock,
  input  logic [1:0]                 op,
  input  logic [31:0]                rnd,
  output cpsb_pkg::cpsb_alu_req_t    alu,
  output cpsb_pkg::cpsb_mirror_req_t mirror
);
  // One driver per output; the bench holds reset past the first edge
  always @(posedge clock) begin
    alu <= '0;
    mirror <= '0;
    if (op == 2'h1) begin
      alu <= {1'b1, rnd[19:0]};
    end
    if (op[1]) begin
      // Bank kept below 16 for small RAM; op 3 misses the mirror
      mirror <= '{1'b1, MIRROR_ADDR | {15'h0000, op[0]},
                  {1'b0, rnd[3:0], rnd[6:4]}};
    end
  end
endmodule : cpsb_cpu_model

// File: sim/testbench.sv
/* Self-checking bench for cpsb_status_word with a CPU-side model.
   Assumes package, model and checker are compiled first. */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("[FAIL] t=%0t got %h exp %h", $time, g, e); \
  end end
module testbench;
  import cpsb_pkg::*;
  logic          clock, reset_n, clk_en, sw_wr, lvl_wr, irq_req;
  logic          irq_enable_instruction, irq_disable_instruction;
  logic          mirror_hit_ff, irq_accept_ff, hit;
  logic [1:0]    lvl_wdata, irq_req_level, op;
  logic [2:0]    reg_idx;
  logic [7:0]    dir_op, byte_hi_in, byte_lo_in, mirror_rdata_ff;
  logic [7:0]    alu_result_ff, mem_byte_lo_addr_ff, mem_byte_hi_addr_ff;
  logic [12:0]   got;
  logic [15:0]   sw_wdata, word_in, w, status_word_ff, greg_addr_ff;
  logic [15:0]   dir_addr_ff, word_joined_ff;
  logic [31:0]   rnd, r;
  cpsb_alu_req_t alu, a;
  cpsb_mirror_req_t mirror;
  int            n_mismatch, cmp_count;

  cpsb_status_word dut (.*);
  cpsb_cpu_model u_cpu (.*);

  always #20 clock = ~clock;

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [15:0] dexp(logic [2:0] wn, logic [7:0] o);
    return o[7] ? DIR_WIN_BASE + {6'h00, wn, o[6:0]} : {8'h00, o};
  endfunction : dexp

  function automatic logic [12:0] fexp(cpsb_alu_req_t q);
    logic [8:0] s;
    logic [4:0] h;
    logic       v;
    if (q.is_sub) begin
      s = {1'b0, q.opa} - q.opb - q.cin;
      h = {1'b0, q.opa[3:0]} - q.opb[3:0] - q.cin;
    end else begin
      s = {1'b0, q.opa} + q.opb + q.cin;
      h = {1'b0, q.opa[3:0]} + q.opb[3:0] + q.cin;
    end
    v = (q.opa[7] ^ q.opb[7] ^ ~q.is_sub) & (s[7] ^ q.opa[7]);
    return {s[7:0], h[4], s[7], s[7:0] == 8'h00, v,
            q.is_shift ? q.shift_out : s[8]};
  endfunction : fexp

  task automatic wr_sw(input logic [15:0] d);
    @(posedge clock);
    sw_wr <= 1'b1;
    sw_wdata <= d;
    @(posedge clock);
    sw_wr <= 1'b0;
    @(posedge clock);
    #1;
  endtask : wr_sw

  task automatic cpu_op(input logic [1:0] o, input logic [31:0] d);
    @(posedge clock);
    op <= o;
    rnd <= d;
    @(posedge clock);
    op <= 2'h0;
    #1;
    a = alu;
    @(posedge clock);
    #1;
    hit = mirror_hit_ff;
    @(posedge clock);
    #1;
  endtask : cpu_op

  task automatic ins(input logic [1:0] ed, input logic [1:0] lv);
    @(posedge clock);
    {irq_enable_instruction, irq_disable_instruction} <= ed;
    {lvl_wr, lvl_wdata} <= {1'b1, lv};
    @(posedge clock);
    {irq_enable_instruction, irq_disable_instruction, lvl_wr} <= '0;
    @(posedge clock);
    #1;
  endtask : ins

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (3000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    {clock, reset_n, sw_wr, lvl_wr, irq_req, op} = '0;
    {irq_enable_instruction, irq_disable_instruction} = '0;
    {lvl_wdata, irq_req_level, reg_idx, dir_op, sw_wdata} = '0;
    {word_in, byte_hi_in, byte_lo_in, rnd} = '0;
    clk_en = 1'b1;
    r = 32'd80282;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    `CHK(status_word_ff, 16'h0030)
    `CHK(greg_addr_ff, GREG_BASE)
    for (int i = 0; i < 40; i++) begin
      r = lfsr(r);
      w = {(i == 0) ? 5'h1F : r[15:11], i[2:0], r[7:0]};
      reg_idx <= r[18:16];
      dir_op <= (i == 0) ? 8'hFF : r[26:19];
      {irq_req, irq_req_level} <= r[29:27];
      word_in <= r[31:16];
      {byte_hi_in, byte_lo_in} <= r[15:0];
      wr_sw(w);
      `CHK(status_word_ff, w)
      `CHK(mirror_rdata_ff, w[15:8])
      `CHK(greg_addr_ff, {GREG_PAGE, w[15:11], reg_idx})
      `CHK(dir_addr_ff, dexp(w[10:8], dir_op))
      `CHK(irq_accept_ff, irq_req & w[6] & (irq_req_level < w[5:4]))
      `CHK({mem_byte_lo_addr_ff, mem_byte_hi_addr_ff}, word_in)
      `CHK(word_joined_ff, {byte_hi_in, byte_lo_in})
    end
    for (int i = 0; i < 40; i++) begin
      r = lfsr(r);
      cpu_op(2'h1, (i == 0) ? 32'h00010100 : (i == 1) ? 32'h00020002 : r);
      got = {alu_result_ff, status_word_ff[7], status_word_ff[3:0]};
      `CHK(got, fexp(a))
    end
    w = status_word_ff;
    cpu_op(2'h2, r);
    `CHK(status_word_ff, {1'b0, r[3:0], r[6:4], w[7:0]})
    `CHK(hit, 1'b1)
    cpu_op(2'h3, ~r);
    `CHK(status_word_ff, {1'b0, r[3:0], r[6:4], w[7:0]})
    `CHK(hit, 1'b0)
    {irq_req, irq_req_level} <= 3'b100;
    ins(2'b01, 2'h1);
    `CHK(status_word_ff[6:4], 3'b001)
    ins(2'b11, 2'h0);
    `CHK(status_word_ff[6:4], 3'b100)
    `CHK(irq_accept_ff, 1'b0)
    ins(2'b10, 2'h1);
    `CHK(irq_accept_ff, 1'b1)
    // Enable low must freeze a word write
    w = status_word_ff;
    clk_en <= 1'b0;
    wr_sw(~w);
    `CHK(status_word_ff, w)
    clk_en <= 1'b1;
    // Reset again in mid-run
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    `CHK(status_word_ff, 16'h0030)
    `CHK(irq_accept_ff, 1'b0)
    report_and_stop();
  end
endmodule : testbench
